// ===== hdl/wdrc_top.v
`timescale 1ns/100ps
`default_nettype none
`include "wdrc_map.vh"

// watchdog with protection levels and reset-cause flags
module wdrc_top #(
	parameter CNT_W = `WDRC_CNT_W,
	parameter BASE_CYCLES = `WDRC_BASE_CYCLES
) (
	input wire i_ref_clk,
	input wire i_rst,
	input wire i_wd_osc,
	input wire i_wd_restart,
	input wire i_legacy_compat_fuse,
	input wire i_wd_always_on_fuse,
	input wire i_poweron_reset,
	input wire i_pin_reset,
	input wire i_brownout_reset,
	input wire i_scan_reset,
	input wire [7:0] i_io_addr,
	input wire i_io_data_space,
	input wire i_io_wr,
	input wire i_io_rd,
	input wire [7:0] i_io_wdata,
	output reg [7:0] o_io_rdata,
	output reg o_wd_reset_pulse,
	output reg [1:0] o_level
);

	// address match for either i/o or data-space addressing
	function addr_hit;
		input [7:0] addr;
		input data_space;
		input [7:0] ofs;
		begin
			if (data_space) begin
				addr_hit = (addr == (ofs + `WDRC_DATA_BIAS)); // R24
			end else begin
				addr_hit = (addr == ofs); // R24
			end
		end
	endfunction

	// oscillator and asynchronous inputs, two stages each
	reg [1:0] osc_sync_q;
	reg osc_prev_q;
	reg [1:0] compat_sync_q;
	reg [1:0] always_on_sync_q;
	reg [1:0] por_sync_q;
	reg [1:0] pin_sync_q;
	reg [1:0] bo_sync_q;
	reg [1:0] scan_sync_q;

	// control state
	reg en_q;
	reg en_d;
	reg [2:0] sel_q;
	reg [2:0] sel_d;
	reg [2:0] unlock_cnt_q;
	reg [2:0] unlock_cnt_d;

	// reset cause flags
	reg [4:0] cause_q;
	reg [4:0] cause_d;

	// derived signals
	wire osc_tick;
	wire compat_fuse;
	wire always_on_fuse;
	wire [1:0] level;
	wire unlock_open;
	wire eff_en;
	wire chip_reset;
	wire ctrl_wr;
	wire cause_wr;
	wire ctrl_rd;
	wire cause_rd;
	wire unlock_req;
	wire wd_expire;
	wire [4:0] cause_mask;
	wire [4:0] cause_set;
	wire [7:0] ctrl_view;
	wire [7:0] cause_view;
	reg [7:0] rdata_d;

	// synchroniser chains; first stage feeds only the second
	always @(posedge i_ref_clk) begin
		if (i_rst) begin
			osc_sync_q <= 2'h0;
			osc_prev_q <= 1'b0;
			compat_sync_q <= 2'h0;
			always_on_sync_q <= 2'h0;
			por_sync_q <= 2'h0;
			pin_sync_q <= 2'h0;
			bo_sync_q <= 2'h0;
			scan_sync_q <= 2'h0;
		end else begin
			osc_sync_q <= {osc_sync_q[0], i_wd_osc}; // R27
			osc_prev_q <= osc_sync_q[1];
			compat_sync_q <= {compat_sync_q[0], i_legacy_compat_fuse};
			always_on_sync_q <= {always_on_sync_q[0], i_wd_always_on_fuse};
			por_sync_q <= {por_sync_q[0], i_poweron_reset};
			pin_sync_q <= {pin_sync_q[0], i_pin_reset};
			bo_sync_q <= {bo_sync_q[0], i_brownout_reset};
			scan_sync_q <= {scan_sync_q[0], i_scan_reset};
		end
	end

	// rising edge of the watchdog oscillator after synchronising
	assign osc_tick = osc_sync_q[1] & ~osc_prev_q; // R1 R27

	// protection level from the two fuses; always-on dominates
	assign compat_fuse = compat_sync_q[1];
	assign always_on_fuse = always_on_sync_q[1];
	assign level = always_on_fuse ? `WDRC_LEVEL2 :
		(compat_fuse ? `WDRC_LEVEL0 : `WDRC_LEVEL1); // R6

	// any chip reset source, including the watchdog's own pulse
	assign chip_reset = por_sync_q[1] | pin_sync_q[1] | bo_sync_q[1] |
		scan_sync_q[1] | o_wd_reset_pulse; // R3

	// change window is open while the countdown is non-zero
	assign unlock_open = (unlock_cnt_q != 3'h0);

	// level 2 keeps the watchdog running whatever is stored
	assign eff_en = en_q | (level == `WDRC_LEVEL2); // R11 R16

	// register decode
	assign ctrl_wr = i_io_wr & addr_hit(i_io_addr, i_io_data_space, `WDRC_CTRL_OFS);
	assign cause_wr = i_io_wr & addr_hit(i_io_addr, i_io_data_space, `WDRC_CAUSE_OFS);
	assign ctrl_rd = i_io_rd & addr_hit(i_io_addr, i_io_data_space, `WDRC_CTRL_OFS);
	assign cause_rd = i_io_rd & addr_hit(i_io_addr, i_io_data_space, `WDRC_CAUSE_OFS);

	// an unlock needs both unlock and enable written as one
	assign unlock_req = ctrl_wr & i_io_wdata[`WDRC_CTRL_UNLOCK_BIT] &
		i_io_wdata[`WDRC_CTRL_EN_BIT]; // R9

	// unlock countdown, cleared by hardware after four cycles
	always @* begin
		unlock_cnt_d = unlock_cnt_q;
		if (chip_reset) begin
			unlock_cnt_d = 3'h0;
		end else if (unlock_req) begin
			unlock_cnt_d = `WDRC_UNLOCK_CYCLES; // R13
		end else if (unlock_open) begin
			unlock_cnt_d = unlock_cnt_q - 3'h1; // R13
		end
	end

	// enable bit: set freely, cleared only inside the window
	always @* begin
		en_d = en_q;
		if (chip_reset) begin
			en_d = 1'b0; // R6
		end else if (ctrl_wr) begin
			if (i_io_wdata[`WDRC_CTRL_EN_BIT]) begin
				en_d = 1'b1; // R7
			end else if (unlock_open && level != `WDRC_LEVEL2) begin
				en_d = 1'b0; // R10 R14 R12 R16
			end
		end
	end

	// period select: free at level 0, windowed otherwise
	always @* begin
		sel_d = sel_q;
		if (chip_reset) begin
			sel_d = 3'h0; // R3
		end else if (ctrl_wr && !unlock_req) begin
			if (level == `WDRC_LEVEL0) begin
				sel_d = i_io_wdata[`WDRC_CTRL_SEL_HI:`WDRC_CTRL_SEL_LO]; // R8
			end else if (unlock_open) begin
				sel_d = i_io_wdata[`WDRC_CTRL_SEL_HI:`WDRC_CTRL_SEL_LO]; // R15 R10 R12
			end
		end else if (ctrl_wr && level == `WDRC_LEVEL0) begin
			sel_d = i_io_wdata[`WDRC_CTRL_SEL_HI:`WDRC_CTRL_SEL_LO]; // R8
		end
	end

	// control registers
	always @(posedge i_ref_clk) begin
		if (i_rst) begin
			en_q <= 1'b0;
			sel_q <= 3'h0;
			unlock_cnt_q <= 3'h0;
		end else begin
			en_q <= en_d;
			sel_q <= sel_d;
			unlock_cnt_q <= unlock_cnt_d;
		end
	end

	// watchdog counter on oscillator ticks
	wdrc_wd_counter #(
		.CNT_W(CNT_W),
		.BASE_CYCLES(BASE_CYCLES)
	) u_counter (
		.i_ref_clk(i_ref_clk),
		.i_rst(i_rst),
		.i_tick(osc_tick),
		.i_clear(i_wd_restart | chip_reset), // R2 R3
		.i_enable(eff_en), // R3
		.i_period_sel(sel_q),
		.o_expire(wd_expire),
		.o_count()
	);

	// legacy mode keeps only the pin and power-on flags
	assign cause_mask = compat_fuse ? `WDRC_CAUSE_LEGACY_MASK : 5'h1f; // R22

	// reset events set their flag; a set beats a clear
	assign cause_set = cause_mask & {
		scan_sync_q[1], // R17
		o_wd_reset_pulse, // R18
		bo_sync_q[1], // R19
		pin_sync_q[1], // R20
		por_sync_q[1] // R21
	};

	// cause flags: power-on clears the others, zeros written clear
	always @* begin
		cause_d = cause_q;
		if (por_sync_q[1]) begin
			cause_d = 5'h00; // R17 R18 R19 R20
		end else if (cause_wr) begin
			cause_d = cause_q & i_io_wdata[4:0]; // R17 R18 R19 R20 R21
		end
		cause_d = (cause_d | cause_set) & cause_mask;
	end

	// cause register; power-on of this block marks bit 0
	always @(posedge i_ref_clk) begin
		if (i_rst) begin
			cause_q <= `WDRC_CAUSE_RESET; // R21
		end else begin
			cause_q <= cause_d;
		end
	end

	// read views; unused bits read as zero
	assign ctrl_view = {3'h0, unlock_open, eff_en, sel_q}; // R11
	assign cause_view = {3'h0, cause_q & cause_mask}; // R22

	// read mux; unmapped addresses return zero
	always @* begin
		rdata_d = 8'h00;
		if (ctrl_rd) begin
			rdata_d = ctrl_view;
		end else if (cause_rd) begin
			rdata_d = cause_view;
		end
	end

	// registered outputs
	always @(posedge i_ref_clk) begin
		if (i_rst) begin
			o_io_rdata <= 8'h00;
			o_wd_reset_pulse <= 1'b0;
			o_level <= 2'h0;
		end else begin
			o_io_rdata <= rdata_d;
			o_wd_reset_pulse <= wd_expire & ~o_wd_reset_pulse; // R5 R25
			o_level <= level;
		end
	end

endmodule
`default_nettype wire

// ===== hdl/wdrc_map.vh
// Contract
// [R1] watchdog counter runs from 1 MHz oscillator
// [R2] restart instruction clears the watchdog counter
// [R3] disable or any chip reset clears counter
// [R4] eight periods chosen by period select field
// [R5] expiry while enabled resets the chip
// [R6] two fuses give protection level 0/1/2
// [R7] writing enable one always enables, no unlock
// [R8] level 0: period writes need no unlock
// [R9] unlock write sets unlock and enable together
// [R10] level 1: new settings within four cycles
// [R11] level 2: always enabled, enable reads one
// [R12] level 2: period change, written enable ignored
// [R13] hardware clears unlock bit four cycles later
// [R14] enable zero ignored unless unlock is set
// [R15] levels 1, 2: period changes only in window
// [R16] level 2: watchdog can never be disabled
// [R17] bit 4 set by scan-chain reset, cleared
// [R18] bit 3 set by watchdog reset, cleared
// [R19] bit 2 set by brown-out reset, cleared
// [R20] bit 1 set by pin reset, cleared
// [R21] bit 0 set by power-on, software clears
// [R22] legacy mode keeps only pin, power-on flags
// [R23] software reads then clears cause flags early
// [R24] registers at offset, plus 0x20 in data space
// [R25] timeout gives one-cycle internal reset pulse
// [R26] codes 0..7 select 16K to 2048K cycles
// [R27] oscillator and commands crossed safely between domains
`ifndef WDRC_MAP_VH
`define WDRC_MAP_VH

// register offsets in i/o space
`define WDRC_CTRL_OFS 8'h21
`define WDRC_CAUSE_OFS 8'h34
`define WDRC_DATA_BIAS 8'h20

// control register fields
`define WDRC_CTRL_UNLOCK_BIT 4
`define WDRC_CTRL_EN_BIT 3
`define WDRC_CTRL_SEL_HI 2
`define WDRC_CTRL_SEL_LO 0
`define WDRC_CTRL_RESET 8'h00

// cause register fields
`define WDRC_CAUSE_SCAN_BIT 4
`define WDRC_CAUSE_TIMEOUT_BIT 3
`define WDRC_CAUSE_BROWNOUT_BIT 2
`define WDRC_CAUSE_PIN_BIT 1
`define WDRC_CAUSE_POWERON_BIT 0
`define WDRC_CAUSE_RESET 5'h01
`define WDRC_CAUSE_LEGACY_MASK 5'h03

// timing
`define WDRC_UNLOCK_CYCLES 3'h4
`define WDRC_OSC_HZ 1000000
`define WDRC_BASE_CYCLES 16384
`define WDRC_CNT_W 22

// protection levels
`define WDRC_LEVEL0 2'h0
`define WDRC_LEVEL1 2'h1
`define WDRC_LEVEL2 2'h2

`endif

// ===== hdl/wdrc_wd_counter.v
`timescale 1ns/100ps
`default_nettype none
`include "wdrc_map.vh"

// counts watchdog oscillator ticks and flags the selected period
module wdrc_wd_counter #(
	parameter CNT_W = `WDRC_CNT_W,
	parameter BASE_CYCLES = `WDRC_BASE_CYCLES
) (
	input wire i_ref_clk,
	input wire i_rst,
	input wire i_tick,
	input wire i_clear,
	input wire i_enable,
	input wire [2:0] i_period_sel,
	output reg o_expire,
	output wire [CNT_W-1:0] o_count
);

	localparam [CNT_W-1:0] BASE_V = BASE_CYCLES;

	reg [CNT_W-1:0] cnt_q;
	reg [CNT_W-1:0] cnt_d;
	reg expire_d;
	wire [CNT_W-1:0] limit;

	// period doubles for each step of the select code
	assign limit = BASE_V << i_period_sel; // R4 R26
	assign o_count = cnt_q;

	// next count: clear wins, then count oscillator ticks
	always @* begin
		cnt_d = cnt_q;
		expire_d = 1'b0;
		if (i_clear || !i_enable) begin
			cnt_d = {CNT_W{1'b0}}; // R2 R3
		end else if (i_tick) begin
			if (cnt_q >= limit - 1'b1) begin
				cnt_d = {CNT_W{1'b0}};
				expire_d = 1'b1; // R5
			end else begin
				cnt_d = cnt_q + 1'b1; // R1
			end
		end
	end

	always @(posedge i_ref_clk) begin
		if (i_rst) begin
			cnt_q <= {CNT_W{1'b0}};
			o_expire <= 1'b0;
		end else begin
			cnt_q <= cnt_d;
			o_expire <= expire_d;
		end
	end

endmodule
`default_nettype wire

// ===== verif/wdrc_chk.sv
`timescale 1ns/100ps
`default_nettype none
// port-level checks of the watchdog and cause register
module wdrc_chk #(
	parameter CNT_W = 22,
	parameter BASE_CYCLES = 16384
) (
	input wire logic i_ref_clk,
	input wire logic i_rst,
	input wire logic [7:0] i_io_addr,
	input wire logic i_io_data_space,
	input wire logic i_io_wr,
	input wire logic i_io_rd,
	input wire logic [7:0] i_io_wdata,
	input wire logic [7:0] o_io_rdata,
	input wire logic o_wd_reset_pulse,
	input wire logic [1:0] o_level
);
	default clocking @(posedge i_ref_clk); endclocking
	default disable iff (i_rst);
	// address decode as seen from the bus
	wire ctl_hit = i_io_addr == (i_io_data_space ? 8'h41 : 8'h21);
	wire cse_hit = i_io_addr == (i_io_data_space ? 8'h54 : 8'h34);
	logic [2:0] since_q;
	// edges since the last write carrying the unlock bit, saturating
	always @(posedge i_ref_clk) begin
		if (i_rst)
			since_q <= 3'h7;
		else if (i_io_wr && ctl_hit && i_io_wdata[4])
			since_q <= 3'h0;
		else if (since_q != 3'h7)
			since_q <= since_q + 3'h1;
	end
	a_pulse_single: assert property (o_wd_reset_pulse |=> !o_wd_reset_pulse)
		else $error("reset pulse longer than one cycle");
	a_rdata_idle: assert property (!i_io_rd |=> o_io_rdata == 8'h00)
		else $error("read data not zero without read");
	a_unmapped_zero: assert property (i_io_rd && !ctl_hit && !cse_hit |=> o_io_rdata == 8'h00)
		else $error("unmapped read not zero");
	a_upper_zero: assert property (i_io_rd |=> o_io_rdata[7:5] == 3'h0)
		else $error("unused bits not zero");
	a_level_legal: assert property (o_level != 2'h3)
		else $error("illegal protection level");
	a_lvl2_enable: assert property (i_io_rd && ctl_hit && o_level == 2'h2 |=> o_io_rdata[3])
		else $error("enable reads zero at level two");
	a_legacy_flags: assert property (i_io_rd && cse_hit && o_level == 2'h0 |=> o_io_rdata[4:2] == 3'h0)
		else $error("legacy mode shows extra flags");
	a_unlock_expiry: assert property (i_io_rd && ctl_hit && since_q >= 3'h4 |=> !o_io_rdata[4])
		else $error("unlock bit outlives its window");
endmodule
bind wdrc_top wdrc_chk #(.CNT_W(CNT_W), .BASE_CYCLES(BASE_CYCLES)) chk_u (
	.i_ref_clk(i_ref_clk), .i_rst(i_rst), .i_io_addr(i_io_addr), .i_io_data_space(i_io_data_space),
	.i_io_wr(i_io_wr), .i_io_rd(i_io_rd), .i_io_wdata(i_io_wdata), .o_io_rdata(o_io_rdata),
	.o_wd_reset_pulse(o_wd_reset_pulse), .o_level(o_level));
`default_nettype wire

// ===== verif/watchdog_with_reset_cause_flags_bench.sv
`timescale 1ns/100ps
`default_nettype none
module watchdog_with_reset_cause_flags_bench;
	logic clk = 0, rst = 1, osc = 0, rstr = 0, leg = 0, aon = 0, ds = 0, wr = 0, rd = 0;
	logic [3:0] src = 4'h0;
	logic [7:0] addr = 8'h00, wdat = 8'h00;
	wire [7:0] rdata;
	wire pulse;
	wire [1:0] lvl;
	int fail_count = 0, num_checks = 0, cyc = 0;
	// cpu clock and free-running watchdog oscillator, unrelated phase
	always #5 clk = ~clk;
	initial begin
		#3;
		forever #500 osc = ~osc;
	end
	wdrc_top #(.CNT_W(22), .BASE_CYCLES(4)) dut_u (.i_ref_clk(clk), .i_rst(rst), .i_wd_osc(osc),
		.i_wd_restart(rstr), .i_legacy_compat_fuse(leg), .i_wd_always_on_fuse(aon),
		.i_poweron_reset(src[0]), .i_pin_reset(src[1]), .i_brownout_reset(src[2]),
		.i_scan_reset(src[3]), .i_io_addr(addr), .i_io_data_space(ds), .i_io_wr(wr), .i_io_rd(rd),
		.i_io_wdata(wdat), .o_io_rdata(rdata), .o_wd_reset_pulse(pulse), .o_level(lvl));
	task give_verdict;
		if (fail_count == 0 && num_checks > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask
	task chk(input logic [7:0] seen, input logic [7:0] exp, input string what);
		num_checks++;
		if (seen !== exp) begin
			fail_count++;
			$display("MISMATCH %s expected %h seen %h", what, exp, seen);
		end
	endtask
	// data-space offsets all have bit 6 set
	task wrr(input logic [7:0] a, input logic [7:0] d);
		@(negedge clk);
		addr = a;
		ds = a[6];
		wdat = d;
		wr = 1;
		@(negedge clk);
		wr = 0;
	endtask
	task rdc(input logic [7:0] a, input logic [7:0] exp, input string what);
		@(negedge clk);
		addr = a;
		ds = a[6];
		rd = 1;
		@(negedge clk);
		rd = 0;
		chk(rdata, exp, what);
	endtask
	task boot(input logic l, input logic a);
		leg = l;
		aon = a;
		rst = 1;
		repeat (5) @(negedge clk);
		rst = 0;
		repeat (3) @(negedge clk);
	endtask
	// enable with a period, restart after pre cycles, time the pulse
	task tmo(input logic [2:0] s, input int pre);
		int n;
		wrr(8'h21, {5'h01, s});
		repeat (pre) @(negedge clk);
		rstr = 1;
		@(negedge clk);
		rstr = 0;
		n = 0;
		while (!pulse && n < 60000) begin
			@(negedge clk);
			n++;
		end
		chk({7'h0, n > (400 << s) - 110 && n < (400 << s) + 200}, 8'h01, "period");
	endtask
	// hang guard
	always @(posedge clk) begin
		cyc++;
		if (cyc == 90000) begin
			fail_count++;
			give_verdict();
		end
	end
	initial begin
		boot(0, 0);
		chk({6'h0, lvl}, 8'h01, "level");
		rdc(8'h34, 8'h01, "cause");
		rdc(8'h41, 8'h00, "ctrl");
		rdc(8'h22, 8'h00, "unmapped");
		wrr(8'h54, 8'h00);
		rdc(8'h34, 8'h00, "cause");
		wrr(8'h21, 8'h0d);
		rdc(8'h21, 8'h08, "ctrl");
		wrr(8'h21, 8'h00);
		rdc(8'h21, 8'h08, "ctrl");
		wrr(8'h21, 8'h18);
		rdc(8'h21, 8'h18, "ctrl");
		wrr(8'h21, 8'h02);
		repeat (6) @(negedge clk);
		rdc(8'h21, 8'h02, "ctrl");
		wrr(8'h41, 8'h18);
		repeat (6) @(negedge clk);
		wrr(8'h21, 8'h00);
		rdc(8'h21, 8'h0a, "ctrl");
		tmo(3'h2, 0);
		rdc(8'h34, 8'h08, "cause");
		rdc(8'h21, 8'h00, "ctrl");
		for (int k = 0; k < 4; k++) begin
			src[(k + 1) % 4] = 1;
			repeat (4) @(negedge clk);
			src[(k + 1) % 4] = 0;
			repeat (6) @(negedge clk);
			if (k == 2)
				rdc(8'h34, 8'h1e, "cause");
		end
		rdc(8'h34, 8'h01, "cause");
		boot(1, 0);
		chk({6'h0, lvl}, 8'h00, "level");
		wrr(8'h21, 8'h0b);
		rdc(8'h21, 8'h0b, "ctrl");
		tmo(3'h0, 300);
		for (int s = 1; s < 4; s++)
			tmo(3'(s), 0);
		tmo(3'h7, 0);
		rdc(8'h34, 8'h01, "cause");
		boot(0, 1);
		chk({6'h0, lvl}, 8'h02, "level");
		rdc(8'h21, 8'h08, "ctrl");
		wrr(8'h21, 8'h18);
		wrr(8'h21, 8'h03);
		repeat (6) @(negedge clk);
		rdc(8'h21, 8'h0b, "ctrl");
		wrr(8'h21, 8'h05);
		rdc(8'h21, 8'h0b, "ctrl");
		give_verdict();
	end
endmodule
`default_nettype wire
